// ### rtl/ivm_pkg.sv
`default_nettype none
package ivm_pkg;
    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_INTERRUPT_ENABLE_REGISTER_0 = 8'h00;
    localparam logic [7:0] OFS_NMICTL = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_CLEAR = 8'h0C;
    localparam logic [7:0] OFS_IRQEN = 8'h10;
    localparam logic [7:0] OFS_VECTOR = 8'h14;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [5:0] RST_INTERRUPT_ENABLE_REGISTER_0 = 6'h00;
    localparam logic [5:0] RST_NMICTL = 6'h00;
    localparam logic [14:0] RST_IRQEN = 15'h0000;

    // ------------------------------------------------------------
    // Source bit positions in status, clear and IRQ enable registers
    // ------------------------------------------------------------
    localparam int NUM_SRC = 15;
    localparam int SRC_EXT0 = 0;
    localparam int SRC_TIMER0 = 1;
    localparam int SRC_EXT1 = 2;
    localparam int SRC_TIMER1 = 3;
    localparam int SRC_SERIAL = 4;
    localparam int SRC_GRP_LO = 5;
    localparam int SRC_GRP_HI = 8;
    localparam int SRC_NMI_LO = 9;
    localparam int SRC_NMI_HI = 14;
    localparam logic [14:0] MASK_GRP = 15'h01E0;
    localparam logic [14:0] MASK_NMI = 15'h7E00;

    // ------------------------------------------------------------
    // Node codes and vector addresses
    // ------------------------------------------------------------
    localparam logic [2:0] NODE_EXT0 = 3'h0;
    localparam logic [2:0] NODE_TIMER0 = 3'h1;
    localparam logic [2:0] NODE_EXT1 = 3'h2;
    localparam logic [2:0] NODE_TIMER1 = 3'h3;
    localparam logic [2:0] NODE_SERIAL = 3'h4;
    localparam logic [2:0] NODE_GRP = 3'h5;
    localparam logic [2:0] NODE_NMI = 3'h6;
    localparam logic [15:0] VEC_EXT0 = 16'h0003;
    localparam logic [15:0] VEC_TIMER0 = 16'h000B;
    localparam logic [15:0] VEC_EXT1 = 16'h0013;
    localparam logic [15:0] VEC_TIMER1 = 16'h001B;
    localparam logic [15:0] VEC_SERIAL = 16'h0023;
    localparam logic [15:0] VEC_GRP = 16'h002B;
    localparam logic [15:0] VEC_NMI = 16'h0073;
endpackage
`default_nettype wire

// ### rtl/sticky_flags.sv
`timescale 1ns/1ps
`default_nettype none
// Sticky flag bank; a set in the same cycle as a clear wins
module sticky_flags #(
    parameter int WIDTH = 15
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Set and clear strobes
    input wire logic [WIDTH-1:0] set_i,
    input wire logic [WIDTH-1:0] clr_i,
    // Flag state
    output logic [WIDTH-1:0] flags_o
);
    logic [WIDTH-1:0] flags_q;
    logic [WIDTH-1:0] flags_d;

    // Set over clear so no event is lost
    assign flags_d = set_i | (flags_q & ~clr_i);
    assign flags_o = flags_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            flags_q <= '0;
        end else begin
            flags_q <= flags_d;
        end
    end
endmodule // sticky_flags
`default_nettype wire

// ### rtl/interrupt_vector_mapping.sv
// Functional notes
// - Each source maps to its node's vector; shared node sources share one vector.
// - Each source outside the 002Bh group has its own enable; the four group sources share one; cleared enable blocks service.
// - External 0 vectors to 0003h, timer 0 to 000Bh, enables in register 0.
// - External 1 to 0013h, timer 1 to 001Bh, serial to 0023h.
// - Timer two, divider overflow, CAN node 0, LIN share 002Bh, one enable.
`timescale 1ns/1ps
`default_nettype none
module interrupt_vector_mapping (
    // Clock and reset
    input wire logic CLK,
    input wire logic SYS_RST,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Peripheral event pulses
    input wire logic EVT_EXT0,
    input wire logic EVT_TIMER0,
    input wire logic EVT_EXT1,
    input wire logic EVT_TIMER1,
    input wire logic EVT_SERIAL,
    input wire logic EVT_TIMER_TWO,
    input wire logic EVT_FDIV_OVF,
    input wire logic EVT_CAN0,
    input wire logic EVT_LIN,
    input wire logic EVT_WATCHDOG,
    input wire logic EVT_PLL,
    input wire logic EVT_FLASH,
    input wire logic EVT_CORE_SUPPLY,
    input wire logic EVT_IO_SUPPLY,
    input wire logic EVT_ECC,
    // Core vector request
    output logic REQ_VALID,
    output logic [15:0] REQ_VECTOR,
    output logic REQ_NMI,
    input wire logic REQ_ACK,
    // Interrupt line
    output logic IRQ
);
    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------
    // Sources that belong to a node
    function automatic logic [14:0] node_mask(input logic [2:0] node);
        logic [14:0] m;
        m = 15'h0000;
        case (node)
            ivm_pkg::NODE_GRP: m = ivm_pkg::MASK_GRP;
            ivm_pkg::NODE_NMI: m = ivm_pkg::MASK_NMI;
            3'h7: m = 15'h0000;
            default: m = 15'h0001 << node;
        endcase
        return m;
    endfunction

    // fixed vector table
    // Vector address of a node
    function automatic logic [15:0] node_vector(input logic [2:0] node);
        logic [15:0] v;
        v = 16'h0000;
        case (node)
            ivm_pkg::NODE_EXT0: v = ivm_pkg::VEC_EXT0;
            ivm_pkg::NODE_TIMER0: v = ivm_pkg::VEC_TIMER0;
            ivm_pkg::NODE_EXT1: v = ivm_pkg::VEC_EXT1;
            ivm_pkg::NODE_TIMER1: v = ivm_pkg::VEC_TIMER1;
            ivm_pkg::NODE_SERIAL: v = ivm_pkg::VEC_SERIAL;
            ivm_pkg::NODE_GRP: v = ivm_pkg::VEC_GRP;
            ivm_pkg::NODE_NMI: v = ivm_pkg::VEC_NMI;
            default: v = 16'h0000;
        endcase
        return v;
    endfunction

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [5:0] interrupt_enable_register_0_q;
    logic [5:0] nmi_control_register_q;
    logic [14:0] irq_en_q;
    logic [31:0] prdata_q;
    logic req_valid_q;
    logic [15:0] req_vector_q;
    logic [2:0] node_q;
    logic [14:0] evt;
    logic [14:0] pend;
    logic [14:0] src_en;
    logic [14:0] svc;
    logic [14:0] svc_left;
    logic [15:0] vec_d;
    logic [14:0] ack_clr;
    logic [14:0] sw_clr;
    logic nmi_hit;
    logic [2:0] node_d;
    logic setup_rd;
    logic wr_en;
    logic addr_ok;
    logic ext0_int_enable;
    logic timer0_int_enable;
    logic ext1_int_enable;
    logic timer1_int_enable;
    logic serial_int_enable;
    logic timer2_group_enable;

    // ------------------------------------------------------------
    // Event capture
    // ------------------------------------------------------------
    // Events share the clock, so no synchroniser is needed
    assign evt = {EVT_ECC, EVT_IO_SUPPLY, EVT_CORE_SUPPLY, EVT_FLASH, EVT_PLL,
                  EVT_WATCHDOG, EVT_LIN, EVT_CAN0, EVT_FDIV_OVF, EVT_TIMER_TWO,
                  EVT_SERIAL, EVT_TIMER1, EVT_EXT1, EVT_TIMER0, EVT_EXT0};

    // Served node or software write clears flags
    assign ack_clr = (REQ_ACK && req_valid_q) ? node_mask(node_q) : 15'h0000;
    assign sw_clr = (wr_en && PADDR == ivm_pkg::OFS_CLEAR) ? PWDATA[14:0] : 15'h0000;

    sticky_flags #(
        .WIDTH(ivm_pkg::NUM_SRC)
    ) u_pend (
        .clk(CLK),
        .rst(SYS_RST),
        .set_i(evt),
        .clr_i(ack_clr | sw_clr),
        .flags_o(pend)
    );

    // ------------------------------------------------------------
    // Enables and node selection
    // ------------------------------------------------------------
    assign ext0_int_enable = interrupt_enable_register_0_q[0];
    assign timer0_int_enable = interrupt_enable_register_0_q[1];
    assign ext1_int_enable = interrupt_enable_register_0_q[2];
    assign timer1_int_enable = interrupt_enable_register_0_q[3];
    assign serial_int_enable = interrupt_enable_register_0_q[4];
    assign timer2_group_enable = interrupt_enable_register_0_q[5];

    assign src_en = {nmi_control_register_q, {4{timer2_group_enable}},
                     serial_int_enable, timer1_int_enable, ext1_int_enable,
                     timer0_int_enable, ext0_int_enable};
    assign svc = pend & src_en;
    // Work left once this cycle's ack lands, so no stale vector follows an ack
    assign svc_left = svc & ~ack_clr;
    assign nmi_hit = |svc_left[ivm_pkg::SRC_NMI_HI:ivm_pkg::SRC_NMI_LO];

    // source to node, fixed priority
    // Non-maskable node first, then lowest vector
    assign node_d = nmi_hit ? ivm_pkg::NODE_NMI :
                    svc_left[ivm_pkg::SRC_EXT0] ? ivm_pkg::NODE_EXT0 :
                    svc_left[ivm_pkg::SRC_TIMER0] ? ivm_pkg::NODE_TIMER0 :
                    svc_left[ivm_pkg::SRC_EXT1] ? ivm_pkg::NODE_EXT1 :
                    svc_left[ivm_pkg::SRC_TIMER1] ? ivm_pkg::NODE_TIMER1 :
                    svc_left[ivm_pkg::SRC_SERIAL] ? ivm_pkg::NODE_SERIAL :
                    (|(svc_left & ivm_pkg::MASK_GRP)) ? ivm_pkg::NODE_GRP :
                    ivm_pkg::NODE_EXT0;
    // Idle shows vector zero, as after reset
    assign vec_d = (|svc_left) ? node_vector(node_d) : 16'h0000;

    // vector register for the core
    // Follows pending state; an acked node drops next cycle
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            req_valid_q <= 1'b0;
            req_vector_q <= 16'h0000;
            node_q <= 3'h0;
        end else begin
            req_valid_q <= |svc_left;
            req_vector_q <= vec_d;
            node_q <= node_d;
        end
    end

    assign REQ_VALID = req_valid_q;
    assign REQ_VECTOR = req_vector_q;
    assign REQ_NMI = req_valid_q && node_q == ivm_pkg::NODE_NMI;
    assign IRQ = |(pend & irq_en_q);

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    // Zero wait states; read data prepared during setup
    assign setup_rd = PSEL && !PENABLE && !PWRITE;
    assign wr_en = PSEL && PENABLE && PWRITE;
    assign addr_ok = PADDR == ivm_pkg::OFS_INTERRUPT_ENABLE_REGISTER_0 || PADDR == ivm_pkg::OFS_NMICTL ||
                     PADDR == ivm_pkg::OFS_STATUS || PADDR == ivm_pkg::OFS_CLEAR ||
                     PADDR == ivm_pkg::OFS_IRQEN || PADDR == ivm_pkg::OFS_VECTOR;
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL && PENABLE && !addr_ok;
    assign PRDATA = prdata_q;

    // Control registers
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            interrupt_enable_register_0_q <= ivm_pkg::RST_INTERRUPT_ENABLE_REGISTER_0;
            nmi_control_register_q <= ivm_pkg::RST_NMICTL;
            irq_en_q <= ivm_pkg::RST_IRQEN;
        end else if (wr_en) begin
            if (PADDR == ivm_pkg::OFS_INTERRUPT_ENABLE_REGISTER_0) interrupt_enable_register_0_q <= PWDATA[5:0];
            if (PADDR == ivm_pkg::OFS_NMICTL) nmi_control_register_q <= PWDATA[5:0];
            if (PADDR == ivm_pkg::OFS_IRQEN) irq_en_q <= PWDATA[14:0];
        end
    end

    // Read mux; clear register reads as zero
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            prdata_q <= 32'h00000000;
        end else if (setup_rd) begin
            case (PADDR)
                ivm_pkg::OFS_INTERRUPT_ENABLE_REGISTER_0: prdata_q <= {26'h0, interrupt_enable_register_0_q};
                ivm_pkg::OFS_NMICTL: prdata_q <= {26'h0, nmi_control_register_q};
                ivm_pkg::OFS_STATUS: prdata_q <= {17'h0, pend};
                ivm_pkg::OFS_IRQEN: prdata_q <= {17'h0, irq_en_q};
                ivm_pkg::OFS_VECTOR: prdata_q <= {req_valid_q, 12'h0, node_q, req_vector_q};
                default: prdata_q <= 32'h00000000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (SYS_RST);

    sequence s_ack_grp;
        REQ_ACK && REQ_VALID && node_q == ivm_pkg::NODE_GRP;
    endsequence

    property p_shared_clear;
        s_ack_grp ##0 (evt == 15'h0000) |=> ((pend & ivm_pkg::MASK_GRP) == 15'h0000);
    endproperty
    a_shared_clear: assert property (p_shared_clear) else $error("group not cleared");

    property p_disabled_silent;
        (svc == 15'h0000) |=> !REQ_VALID;
    endproperty
    a_disabled_silent: assert property (p_disabled_silent) else $error("disabled source served");

    property p_ext0_vec;
        (svc_left == 15'h0001) |=> REQ_VALID && REQ_VECTOR == ivm_pkg::VEC_EXT0;
    endproperty
    a_ext0_vec: assert property (p_ext0_vec) else $error("ext0 vector wrong");

    property p_timer0_vec;
        (svc_left == 15'h0002) |=> REQ_VECTOR == ivm_pkg::VEC_TIMER0;
    endproperty
    a_timer0_vec: assert property (p_timer0_vec) else $error("timer0 vector wrong");

    property p_serial_vec;
        (svc_left == 15'h0010) |=> REQ_VECTOR == ivm_pkg::VEC_SERIAL;
    endproperty
    a_serial_vec: assert property (p_serial_vec) else $error("serial vector wrong");

    property p_grp_vec;
        (svc_left != 15'h0000 && (svc_left & ~ivm_pkg::MASK_GRP) == 15'h0000)
            |=> REQ_VECTOR == ivm_pkg::VEC_GRP;
    endproperty
    a_grp_vec: assert property (p_grp_vec) else $error("group vector wrong");

    property p_nmi_vec;
        nmi_hit |=> REQ_VALID && REQ_NMI && REQ_VECTOR == ivm_pkg::VEC_NMI;
    endproperty
    a_nmi_vec: assert property (p_nmi_vec) else $error("nmi not first");

    property p_event_held;
        (evt[ivm_pkg::SRC_EXT1] && !ext1_int_enable) |=> pend[ivm_pkg::SRC_EXT1];
    endproperty
    a_event_held: assert property (p_event_held) else $error("event lost");
endmodule // interrupt_vector_mapping
`default_nettype wire

// ### bench/core_vector_model.sv
`timescale 1ns/1ps
`default_nettype none
// Core side: takes the shown vector after a chosen number of cycles
module core_vector_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Request from the mapper
    input wire logic req_valid,
    input wire logic [15:0] req_vector,
    // Bench control: take at all, and how long to dawdle
    input wire logic go,
    input wire logic [3:0] lag,
    // Acknowledge and record of what was taken
    output logic req_ack,
    output logic [15:0] took_vec,
    output logic [15:0] took_cnt
);
    logic [3:0] wait_q;

    // One-cycle ack; vector read at the edge that samples the ack,
    // since a higher node may overtake the one first shown
    always_ff @(posedge clk) begin
        if (rst) begin
            req_ack <= 1'b0;
            wait_q <= 4'h0;
            took_vec <= 16'h0000;
            took_cnt <= 16'h0000;
        end else if (req_ack) begin
            req_ack <= 1'b0;
            wait_q <= 4'h0;
            if (req_valid) begin
                took_vec <= req_vector;
                took_cnt <= took_cnt + 16'h0001;
            end
        end else if (go && req_valid) begin
            if (wait_q >= lag) begin
                req_ack <= 1'b1;
            end else begin
                wait_q <= wait_q + 4'h1;
            end
        end else begin
            wait_q <= 4'h0;
        end
    end
endmodule // core_vector_model
`default_nettype wire

// ### bench/tb_interrupt_vector_mapping.sv
`timescale 1ns/1ps
`default_nettype none
module tb_interrupt_vector_mapping;
    logic clk, rst, psel, penable, pwrite, pready, pslverr, err, go;
    logic irq, req_valid, req_nmi, req_ack;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, wv;
    logic [14:0] evt, m;
    logic [15:0] req_vector, took_vec, took_cnt;
    logic [5:0] ie, nm;
    logic [3:0] lag;
    int error_cnt, check_count, seed, k;

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    interrupt_vector_mapping uut (.CLK(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .EVT_EXT0(evt[0]), .EVT_TIMER0(evt[1]), .EVT_EXT1(evt[2]),
        .EVT_TIMER1(evt[3]), .EVT_SERIAL(evt[4]), .EVT_TIMER_TWO(evt[5]),
        .EVT_FDIV_OVF(evt[6]), .EVT_CAN0(evt[7]), .EVT_LIN(evt[8]), .EVT_WATCHDOG(evt[9]),
        .EVT_PLL(evt[10]), .EVT_FLASH(evt[11]), .EVT_CORE_SUPPLY(evt[12]),
        .EVT_IO_SUPPLY(evt[13]), .EVT_ECC(evt[14]), .REQ_VALID(req_valid),
        .REQ_VECTOR(req_vector), .REQ_NMI(req_nmi), .REQ_ACK(req_ack), .IRQ(irq));

    core_vector_model core (.clk(clk), .rst(rst), .req_valid(req_valid),
        .req_vector(req_vector), .go(go), .lag(lag), .req_ack(req_ack),
        .took_vec(took_vec), .took_cnt(took_cnt));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Setup then access; request held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Waits as long as the slave stalls; only the watchdog ends it
        @(posedge clk);
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic pulse(input logic [14:0] v);
        @(posedge clk);
        evt <= v;
        @(posedge clk);
        evt <= 15'h0000;
    endtask

    // Bounded wait for the core to take one vector
    task automatic take;
        logic [15:0] c;
        int n;
        c = took_cnt;
        n = 0;
        while (took_cnt === c && n < 40) begin
            @(posedge clk);
            n++;
        end
        chk(32'(n < 40), 32'h1);
    endtask

    function automatic logic [15:0] vec_of(input int i);
        case (i)
            0: return ivm_pkg::VEC_EXT0;
            1: return ivm_pkg::VEC_TIMER0;
            2: return ivm_pkg::VEC_EXT1;
            3: return ivm_pkg::VEC_TIMER1;
            4: return ivm_pkg::VEC_SERIAL;
            5, 6, 7, 8: return ivm_pkg::VEC_GRP;
            default: return ivm_pkg::VEC_NMI;
        endcase
    endfunction

    function automatic logic [2:0] node_of(input int i);
        return (i < 5) ? 3'(i) : ((i < 9) ? ivm_pkg::NODE_GRP : ivm_pkg::NODE_NMI);
    endfunction

    task end_of_test;
        $display("errors %0d checks %0d", error_cnt, check_count);
        if (error_cnt == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Watchdog, far beyond the expected thousand or so cycles
    initial begin
        #200000;
        error_cnt++;
        end_of_test;
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {rst, psel, penable, pwrite, go} = 5'b10000;
        paddr = 8'h00;
        pwdata = 32'h0;
        evt = 15'h0000;
        lag = 4'h0;
        seed = 9;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        // Reset values, clear register reads zero
        for (k = 0; k < 6; k++) begin
            apb(1'b0, 8'(4 * k), 32'h0);
            chk(rd, 32'h0);
            chk(32'(err), 32'h0);
        end
        // Unmapped place refused
        apb(1'b1, 8'h18, 32'hFFFFFFFF);
        chk(32'(err), 32'h1);
        apb(1'b0, 8'h18, 32'h0);
        chk({rd[30:0], err}, 32'h1);
        // Enable register 0 and NMI control keep only their defined bits
        repeat (4) begin
            wv = $random(seed);
            apb(1'b1, ivm_pkg::OFS_INTERRUPT_ENABLE_REGISTER_0, wv);
            apb(1'b0, ivm_pkg::OFS_INTERRUPT_ENABLE_REGISTER_0, 32'h0);
            chk(rd, {26'h0, wv[5:0]});
            apb(1'b1, ivm_pkg::OFS_NMICTL, ~wv);
            apb(1'b0, ivm_pkg::OFS_NMICTL, 32'h0);
            chk(rd, {26'h0, ~wv[5:0]});
        end
        // Each source: blocked by its own enable, then served at its vector
        for (k = 0; k < 15; k++) begin
            ie = (k < 9) ? ~(6'h01 << ((k < 5) ? k : 5)) : 6'h3F;
            nm = (k < 9) ? 6'h3F : ~(6'h01 << (k - 9));
            apb(1'b1, ivm_pkg::OFS_INTERRUPT_ENABLE_REGISTER_0, {26'h0, ie});
            apb(1'b1, ivm_pkg::OFS_NMICTL, {26'h0, nm});
            lag <= 4'($random(seed) & 7);
            pulse(15'h0001 << k);
            repeat (4) @(posedge clk);
            chk(32'(req_valid), 32'h0);
            apb(1'b0, ivm_pkg::OFS_STATUS, 32'h0);
            chk(rd, 32'h1 << k);
            apb(1'b1, ivm_pkg::OFS_INTERRUPT_ENABLE_REGISTER_0, 32'h3F);
            apb(1'b1, ivm_pkg::OFS_NMICTL, 32'h3F);
            repeat (3) @(posedge clk);
            chk({req_valid, req_nmi, req_vector}, {1'b1, 1'(k > 8), vec_of(k)});
            apb(1'b0, ivm_pkg::OFS_VECTOR, 32'h0);
            chk(rd, {1'b1, 12'h0, node_of(k), vec_of(k)});
            go <= 1'b1;
            take;
            chk(32'(took_vec), 32'(vec_of(k)));
            go <= 1'b0;
            apb(1'b0, ivm_pkg::OFS_STATUS, 32'h0);
            chk(rd, 32'h0);
        end
        // Random mixes: priority order, shared node taken once
        repeat (6) begin
            m = 15'($random(seed)) | 15'h0001;
            lag <= 4'($random(seed) & 7);
            pulse(m);
            repeat (3) @(posedge clk);
            go <= 1'b1;
            if (|m[14:9]) begin
                take;
                chk(32'(took_vec), 32'(ivm_pkg::VEC_NMI));
            end
            for (k = 0; k < 5; k++) begin
                if (m[k]) begin
                    take;
                    chk(32'(took_vec), 32'(vec_of(k)));
                end
            end
            if (|m[8:5]) begin
                take;
                chk(32'(took_vec), 32'(ivm_pkg::VEC_GRP));
            end
            go <= 1'b0;
            repeat (4) @(posedge clk);
            chk(32'(req_valid), 32'h0);
        end
        // Interrupt line: raise, mask, clear
        apb(1'b1, ivm_pkg::OFS_INTERRUPT_ENABLE_REGISTER_0, 32'h0);
        apb(1'b1, ivm_pkg::OFS_NMICTL, 32'h0);
        k = $unsigned($random(seed)) % 15;
        apb(1'b1, ivm_pkg::OFS_IRQEN, 32'h1 << k);
        pulse(15'h0001 << k);
        repeat (2) @(posedge clk);
        chk(32'(irq), 32'h1);
        apb(1'b1, ivm_pkg::OFS_IRQEN, 32'h0);
        @(negedge clk);
        chk(32'(irq), 32'h0);
        apb(1'b1, ivm_pkg::OFS_IRQEN, 32'h1 << k);
        apb(1'b1, ivm_pkg::OFS_CLEAR, 32'h1 << k);
        @(negedge clk);
        chk(32'(irq), 32'h0);
        apb(1'b0, ivm_pkg::OFS_STATUS, 32'h0);
        chk(rd, 32'h0);
        end_of_test;
    end
endmodule // tb_interrupt_vector_mapping
`default_nettype wire
